// *** hw/cfs_top.sv ***
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/1ps
module cfs_top #(
	parameter int unsigned SAMPLE_CYC = cfs_pkg::SAMPLE_CYC
)(
	input  wire logic        core_clk_i,      // 40 MHz clock
	input  wire logic        rst_n_i,         // Sync reset, low
	input  wire logic [23:0] first_mag_i,     // First input magnitude
	input  wire logic [23:0] second_mag_i,    // Second input magnitude
	input  wire logic [23:0] volt_mag_i,      // Voltage magnitude
	input  wire logic [7:0]  addr_i,          // Register address
	input  wire logic [7:0]  wdata_i,         // Write data
	input  wire logic        wr_i,            // Write strobe
	input  wire logic        rd_i,            // Read strobe
	output logic      [7:0]  rdata_o,         // Read data, next cycle
	output logic             use_second_o,    // Measure on second input
	output logic             fault_o,         // Fault condition now
	output logic             irq_o            // Interrupt level
);
	// Averaged magnitudes of both current inputs
	logic [23:0] avg_a_q;
	logic [23:0] avg_a_d;
	logic [23:0] avg_b_q;
	logic [23:0] avg_b_d;

	// Sample-rate divider and confirmation counter
	logic [31:0] tick_cnt_q;
	logic [31:0] tick_cnt_d;
	logic [7:0]  confirm_q;
	logic [7:0]  confirm_d;
	logic        tick;

	// Selection and fault state
	logic        sel_b_q;
	logic        sel_b_d;
	logic        fault_q;
	logic        fault_d;

	// Software controls and the sticky fault-change flag
	logic        pol_q;
	logic        pol_d;
	logic        f1_q;
	logic        f1_d;
	logic        f2_q;
	logic        f2_d;
	logic        en_q;
	logic        en_d;
	logic        flag_q;
	logic        flag_d;

	// Output stage, every output leaves a flop
	logic [7:0]  rdata_q;
	logic [7:0]  rdata_d;
	logic        irq_q;
	logic        irq_d;
	logic        use_b_q;
	logic        fault_out_q;

	// Single-pole IIR: x += (in - x) >> shift
	function automatic logic [23:0] iir(input logic [23:0] x,
		input logic [23:0] s);
		logic [24:0] d;
		d = {1'b0, s} - {1'b0, x};
		iir = x + 24'($signed(d) >>> cfs_pkg::AVG_SHIFT);
	endfunction

	// True when a exceeds b by more than 1/16 of r
	function automatic logic over(input logic [23:0] a,
		input logic [23:0] b, input logic [23:0] r);
		over = (a > b) &&
			((a - b) > (r >> cfs_pkg::MARGIN_SHIFT));
	endfunction

	// Register address match, shared by write and read decoding
	function automatic logic is_reg(input logic [7:0] a,
		input logic [7:0] r);
		is_reg = (a == r);
	endfunction

	// Address decoding
	wire         sel_acc  = is_reg(addr_i, cfs_pkg::ACC_MODE_ADDR);
	wire         sel_cal  = is_reg(addr_i, cfs_pkg::CAL_MODE_ADDR);
	wire         sel_en   = is_reg(addr_i, cfs_pkg::IRQ_EN_ADDR);
	wire         sel_st   = is_reg(addr_i, cfs_pkg::IRQ_ST_ADDR);
	wire         sel_volt = is_reg(addr_i, cfs_pkg::VOLT_LVL_ADDR);
	wire         wr_acc   = wr_i && sel_acc;
	wire         wr_cal   = wr_i && sel_cal;
	wire         wr_en    = wr_i && sel_en;
	wire         wr_st    = wr_i && sel_st;

	// Sample-rate enable pulse
	assign tick = (tick_cnt_q == SAMPLE_CYC - 1);
	assign tick_cnt_d = tick ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;

	// Averaging filters, stepped once per sample
	assign avg_a_d = tick ? iir(avg_a_q, first_mag_i)
		: avg_a_q;
	assign avg_b_d = tick ? iir(avg_b_q, second_mag_i)
		: avg_b_q;

	// Active and inactive averages, following the current selection
	wire  [23:0] act_m = sel_b_q ? avg_b_q : avg_a_q;
	wire  [23:0] ina_m = sel_b_q ? avg_a_q : avg_b_q;
	wire         volt_ok =
		(volt_mag_i >= cfs_pkg::VOLT_MIN);
	// Mismatch of more than 1/16 of the active input, either direction
	wire         mismatch = over(act_m, ina_m, act_m) ||
		over(ina_m, act_m, act_m);
	// Margin taken from the larger input gives hysteresis against chatter
	wire         swap_need = over(ina_m, act_m, ina_m);

	// A change needs CONFIRM_SAMPLES+1 qualifying samples in a row
	wire         at_confirm = (confirm_q == 8'(cfs_pkg::CONFIRM_SAMPLES));
	wire         pending = (mismatch != fault_q);
	wire         qualify = volt_ok && (pending || swap_need);
	wire         decide = tick && volt_ok && at_confirm;
	assign confirm_d = !tick ? confirm_q :
		(!qualify || at_confirm) ? 8'h00 : confirm_q + 8'h01;

	// Fault state and automatic selection move only on a decision
	assign fault_d = decide ? mismatch : fault_q;
	assign sel_b_d = (decide && swap_need) ? ~sel_b_q
		: sel_b_q;

	// Force bits override only the output selection, not the tracking
	wire         forced = f1_q ^ f2_q;
	wire         use_b = forced ? f2_q : sel_b_q;

	// Fault-change event, direction chosen by the polarity control
	wire         changed = (fault_d != fault_q);
	wire         event_set = changed &&
		(pol_q ? !fault_d : fault_d);
	wire         st_clr = wr_st && wdata_i[cfs_pkg::FAULT_BIT];

	// Set wins over a clear in the same cycle
	assign flag_d = event_set ? 1'b1 :
		st_clr ? 1'b0 : flag_q;
	assign irq_d = flag_d && en_q;

	// Register writes
	assign pol_d = wr_acc ? wdata_i[cfs_pkg::POLARITY_BIT] : pol_q;
	assign f1_d = wr_cal ? wdata_i[cfs_pkg::FORCE_FIRST_BIT] : f1_q;
	assign f2_d = wr_cal ? wdata_i[cfs_pkg::FORCE_SECOND_BIT] : f2_q;
	assign en_d = wr_en ? wdata_i[cfs_pkg::FAULT_BIT] : en_q;

	// Read path
	wire  [7:0]  rd_acc = {use_b, pol_q, 6'h00};
	wire  [7:0]  rd_cal = {6'h00, f2_q, f1_q};
	wire  [7:0]  rd_en = {2'h0, en_q, 5'h00};
	wire  [7:0]  rd_st = {2'h0, flag_q, 5'h00};
	wire  [7:0]  rd_volt = {7'h00, volt_ok};
	wire  [7:0]  rd_mux =
		sel_acc ? rd_acc :
		sel_cal ? rd_cal :
		sel_en ? rd_en :
		sel_st ? rd_st :
		sel_volt ? rd_volt : 8'h00;
	// Zero outside the read slot, so a stray sample reads nothing
	assign rdata_d = rd_i ? rd_mux : 8'h00;

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			tick_cnt_q <= 32'h0000_0000;
		end
		else
		begin
			tick_cnt_q <= tick_cnt_d;
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			avg_a_q <= 24'h00_0000;
		end
		else
		begin
			avg_a_q <= avg_a_d;
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			avg_b_q <= 24'h00_0000;
		end
		else
		begin
			avg_b_q <= avg_b_d;
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			confirm_q <= 8'h00;
		end
		else
		begin
			confirm_q <= confirm_d;
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			sel_b_q <= 1'b0;
		end
		else
		begin
			sel_b_q <= sel_b_d;
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			fault_q <= 1'b0;
		end
		else
		begin
			fault_q <= fault_d;
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			pol_q <= cfs_pkg::ACC_MODE_RST[cfs_pkg::POLARITY_BIT];
		end
		else
		begin
			pol_q <= pol_d;
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			f1_q <= cfs_pkg::CAL_MODE_RST[cfs_pkg::FORCE_FIRST_BIT];
		end
		else
		begin
			f1_q <= f1_d;
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			f2_q <= cfs_pkg::CAL_MODE_RST[cfs_pkg::FORCE_SECOND_BIT];
		end
		else
		begin
			f2_q <= f2_d;
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			en_q <= cfs_pkg::IRQ_RST[cfs_pkg::FAULT_BIT];
		end
		else
		begin
			en_q <= en_d;
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			flag_q <= 1'b0;
		end
		else
		begin
			flag_q <= flag_d;
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			rdata_q <= 8'h00;
		end
		else
		begin
			rdata_q <= rdata_d;
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			irq_q <= 1'b0;
		end
		else
		begin
			irq_q <= irq_d;
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			use_b_q <= 1'b0;
		end
		else
		begin
			use_b_q <= use_b;
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			fault_out_q <= 1'b0;
		end
		else
		begin
			fault_out_q <= fault_q;
		end
	end

	assign rdata_o = rdata_q;
	assign irq_o = irq_q;
	assign use_second_o = use_b_q;
	assign fault_o = fault_out_q;
endmodule

// *** hw/cfs_pkg.sv ***
// Overview of operation
// - Fault when difference exceeds 1/16 of active
// - Fault with larger inactive input swaps input
// - During fault measure on the larger input
// - First input selected after reset
// - Inputs averaged so fault needs sustained mismatch
// - Detection inhibited below 0.3% voltage full scale
// - Bit 7 of accumulation mode shows input
// - One force bit set forces that input
// - Force bits equal means automatic selection
// - Fault changes set flag bit 5 status
// - Polarity bit 6 picks entering or leaving
// - Flag and enable pend measurement interrupt
// - Second below 93.75% of first flags fault
// - Both inputs filtered, delay about one second
// - Larger active input keeps billing, no swap
// - Swap back only past same margin
// - Enable bit 5 of interrupt enable one
package cfs_pkg;
	localparam int unsigned AW = 8;
	localparam int unsigned MAG_W = 24;
	localparam logic [7:0] ACC_MODE_ADDR = 8'h0F;
	localparam logic [7:0] CAL_MODE_ADDR = 8'h3D;
	localparam logic [7:0] IRQ_EN_ADDR = 8'hD9;
	localparam logic [7:0] IRQ_ST_ADDR = 8'hDC;
	localparam logic [7:0] VOLT_LVL_ADDR = 8'hE0;
	localparam int unsigned ACTIVE_BIT = 7;
	localparam int unsigned POLARITY_BIT = 6;
	localparam int unsigned FAULT_BIT = 5;
	localparam int unsigned FORCE_FIRST_BIT = 0;
	localparam int unsigned FORCE_SECOND_BIT = 1;
	localparam logic [7:0] ACC_MODE_RST = 8'h00;
	localparam logic [7:0] CAL_MODE_RST = 8'h00;
	localparam logic [7:0] IRQ_RST = 8'h00;
	localparam int unsigned MARGIN_SHIFT = 4;
	localparam logic [MAG_W-1:0] VOLT_FULL_SCALE = 24'h28_F5C2;
	localparam int unsigned VOLT_MIN_PERMILLE = 3;
	localparam logic [MAG_W-1:0] VOLT_MIN =
		MAG_W'(32'(VOLT_FULL_SCALE) * VOLT_MIN_PERMILLE / 1000);
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned AVG_SHIFT = 4;
	localparam int unsigned SAMPLE_US = 50_000;
	localparam int unsigned SAMPLE_CYC = CLK_HZ / 1_000_000 * SAMPLE_US;
	localparam int unsigned FAULT_MS = 1000;
	localparam int unsigned CONFIRM_SAMPLES = FAULT_MS * 1000 / SAMPLE_US;
endpackage

// *** sim/cfs_properties.sv ***
`timescale 1ns/1ps
module cfs_properties(
	input wire logic        core_clk_i,   // Clock
	input wire logic        rst_n_i,      // Reset
	input wire logic [23:0] first_mag_i,  // First
	input wire logic [23:0] second_mag_i, // Second
	input wire logic [23:0] volt_mag_i,   // Voltage
	input wire logic [7:0]  addr_i,       // Address
	input wire logic [7:0]  wdata_i,      // Data
	input wire logic        wr_i,         // Write
	input wire logic        rd_i,         // Read
	input wire logic [7:0]  rdata_o,      // Read data
	input wire logic        use_second_o, // Input used
	input wire logic        fault_o,      // Fault
	input wire logic        irq_o         // Interrupt
);
	logic [1:0]  frc_q;
	logic        en_q;
	wire         frc_eq = frc_q[0] == frc_q[1];
	wire  [23:0] mx = first_mag_i > second_mag_i ? first_mag_i : second_mag_i;
	wire  [23:0] mn = first_mag_i > second_mag_i ? second_mag_i : first_mag_i;
	wire         clr = wr_i && (addr_i == 8'hDC || addr_i == 8'hD9);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	always_ff @(posedge core_clk_i)
		if (!rst_n_i || (wr_i && addr_i == cfs_pkg::CAL_MODE_ADDR))
			frc_q <= rst_n_i ? wdata_i[1:0] : 2'b00;
	always_ff @(posedge core_clk_i)
		if (!rst_n_i || (wr_i && addr_i == cfs_pkg::IRQ_EN_ADDR))
			en_q <= rst_n_i && wdata_i[5];
	a_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00)
		else $error("read data outside read slot");
	a_active_bit: assert property (rd_i && addr_i == 8'h0F
		|=> rdata_o[7] == use_second_o) else $error("active bit");
	a_reset_first: assert property (!$past(rst_n_i)
		|-> !use_second_o && !fault_o && !irq_o) else $error("reset out");
	a_force_first: assert property (frc_q == 2'b01 [*2]
		|-> !use_second_o) else $error("force first ignored");
	a_force_second: assert property (frc_q == 2'b10 [*2]
		|-> use_second_o) else $error("force second ignored");
	a_auto_swap: assert property ($changed(use_second_o) && frc_eq
		&& $past(frc_eq) |-> use_second_o == (second_mag_i > first_mag_i))
		else $error("swap to smaller input");
	a_low_volt: assert property ((volt_mag_i < cfs_pkg::VOLT_MIN) [*8]
		|=> !$rose(fault_o)) else $error("fault at low voltage");
	a_fault_margin: assert property ($rose(fault_o)
		|-> mx - mn > (mn >> 4)) else $error("fault below margin");
	a_irq_enable: assert property (irq_o |-> $past(en_q))
		else $error("interrupt without enable");
	a_flag_sticky: assert property (irq_o && !clr && !$past(clr)
		|=> irq_o) else $error("interrupt dropped on its own");
endmodule
bind cfs_top cfs_properties u_cfs_properties(.core_clk_i, .rst_n_i,
	.first_mag_i, .second_mag_i, .volt_mag_i, .addr_i, .wdata_i, .wr_i,
	.rd_i, .rdata_o, .use_second_o, .fault_o, .irq_o);

// *** sim/cfs_mcu.sv ***
`timescale 1ns/1ps
module cfs_mcu(
	input  wire logic clk_i,  // Clock
	input  wire logic irq_i,  // Interrupt level
	output int        hits_o  // Interrupts taken
);
	logic last_q = 1'b0;
	initial hits_o = 0;
	always @(posedge clk_i)
	begin
		last_q <= irq_i;
		if (irq_i && !last_q)
			hits_o <= hits_o + 1;
	end
endmodule

// *** sim/cfs_top_tb.sv ***
`timescale 1ns/1ps
module cfs_top_tb;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [23:0] fa = 24'h10_0000;
	logic [23:0] fb = 24'h10_0000;
	logic [23:0] vm = 24'h00_0000;
	logic [7:0]  ad = 8'h00;
	logic [7:0]  wd = 8'h00;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	wire  [7:0]  rdata;
	wire         use2;
	wire         flt;
	wire         irq;
	int          hits;
	int          error_cnt = 0;
	int          checked = 0;
	int          i;
	logic [23:0] rows [6] = '{24'h0F_C040, 24'h3D_0202, 24'hD9_2020,
		24'hDC_FF00, 24'h55_FF00, 24'hE0_FF00};
	always #12.5 clk = ~clk;
	cfs_top #(.SAMPLE_CYC(4)) u_cfs_top(.core_clk_i(clk), .rst_n_i(rst_n),
		.first_mag_i(fa), .second_mag_i(fb), .volt_mag_i(vm), .addr_i(ad),
		.wdata_i(wd), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
		.use_second_o(use2), .fault_o(flt), .irq_o(irq));
	cfs_mcu u_cfs_mcu(.clk_i(clk), .irq_i(irq), .hits_o(hits));
	task chk(input logic [7:0] s, input logic [7:0] e);
		checked++;
		if (s !== e)
		begin
			error_cnt++;
			$display("wrong value at %0t: saw %h want %h", $time, s, e);
		end
	endtask
	task give_verdict;
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task wrt(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		ad <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task rdc(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		ad <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk(rdata, e);
	endtask
	// Bounded so a dead detector ends the run instead of hanging it
	task hold(input bit sel, input logic v);
		for (i = 0; i < 5000 && (sel ? use2 : flt) !== v; i++)
			@(posedge clk);
		if (i == 5000)
		begin
			error_cnt++;
			give_verdict();
		end
		repeat (2) @(negedge clk);
	endtask
	initial
	begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		chk({5'h00, use2, flt, irq}, 8'h00);
		foreach (rows[k])
		begin
			wrt(rows[k][23:16], rows[k][15:8]);
			rdc(rows[k][23:16], rows[k][7:0]);
		end
		chk({7'h00, use2}, 8'h01);
		wrt(8'h3D, 8'h00);
		wrt(8'h0F, 8'h00);
		@(negedge clk);
		chk({7'h00, use2}, 8'h00);
		@(posedge clk);
		vm <= cfs_pkg::VOLT_FULL_SCALE;
		fb <= 24'h08_0000;
		rdc(8'hE0, 8'h01);
		hold(1'b0, 1'b1);
		chk({6'h00, use2, irq}, 8'h01);
		rdc(8'hDC, 8'h20);
		chk(hits[7:0], 8'h01);
		wrt(8'hDC, 8'h20);
		fb <= 24'h20_0000;
		hold(1'b1, 1'b1);
		chk({7'h00, irq}, 8'h00);
		rdc(8'h0F, 8'h80);
		wrt(8'h3D, 8'h01);
		repeat (2) @(negedge clk);
		chk({7'h00, use2}, 8'h00);
		wrt(8'h3D, 8'h03);
		repeat (2) @(negedge clk);
		chk({7'h00, use2}, 8'h01);
		wrt(8'h0F, 8'h40);
		wrt(8'hDC, 8'h20);
		fb <= 24'h10_0000;
		hold(1'b0, 1'b0);
		rdc(8'hDC, 8'h20);
		chk(hits[7:0], 8'h02);
		// Low voltage: a sustained mismatch must not raise a fault
		@(posedge clk);
		vm <= 24'h00_0000;
		fb <= 24'h08_0000;
		repeat (400) @(posedge clk);
		@(negedge clk);
		chk({7'h00, flt}, 8'h00);
		rdc(8'hE0, 8'h00);
		// Reset in mid-run returns to the first input and clears all
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		chk({5'h00, use2, flt, irq}, 8'h00);
		rdc(8'hDC, 8'h00);
		rdc(8'h0F, 8'h00);
		give_verdict();
	end
endmodule
